// *** jxl_axi_slave.sv ***
// AXI4-Lite slave front end: takes one write and one read, hands them on as strobes
module jxl_axi_slave (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Write channels
  input wire logic [jxl_pkg::JXL_ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // Read channels
  input wire logic [jxl_pkg::JXL_ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Register file side
  output logic wr_en_out,
  output logic [11:0] wr_idx_out,
  output logic [7:0] wr_data_out,
  output logic rd_en_out,
  output logic [11:0] rd_idx_out,
  input wire logic [7:0] rd_data_in,
  input wire logic wr_hit_in,
  input wire logic rd_hit_in
);
  import jxl_pkg::*;
  logic aw_have_q, w_have_q, rd_wait_q;
  logic [11:0] aw_idx_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic skip_clr;

  // A write with byte lane 0 off stores nothing, but must still free both halves,
  // otherwise the readies would stay low for good after its response
  assign skip_clr = aw_have_q && w_have_q && !w_lane_q && !bvalid_out;

  // Write address and data are latched separately, in either order
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_idx_q <= 12'h000;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_have_q <= 1'b1;
        aw_idx_q <= awaddr_in[13:2];
      end
      if (wvalid_in && wready_out) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata_in[7:0];
        w_lane_q <= wstrb_in[0];
      end
      if (wr_en_out || skip_clr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // Ready only while a slot is free and no response is pending
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      awready_out <= 1'b0;
      wready_out <= 1'b0;
    end else begin
      awready_out <= !aw_have_q && !(awvalid_in && awready_out) && !bvalid_out && !wr_en_out;
      wready_out <= !w_have_q && !(wvalid_in && wready_out) && !bvalid_out && !wr_en_out;
    end
  end

  // Write strobe fires once both halves are held; lane 0 byte enable gates storage
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wr_en_out <= 1'b0;
      wr_idx_out <= 12'h000;
      wr_data_out <= 8'h00;
    end else begin
      wr_en_out <= aw_have_q && w_have_q && !wr_en_out && !bvalid_out && w_lane_q;
      wr_idx_out <= aw_idx_q;
      wr_data_out <= w_data_q;
    end
  end

  // Write response; a write with byte lane 0 off completes with no effect
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      bvalid_out <= 1'b0;
      bresp_out <= JXL_RESP_OKAY;
    end else if (bvalid_out) begin
      if (bready_in) bvalid_out <= 1'b0;
    end else if (wr_en_out) begin
      bvalid_out <= 1'b1;
      bresp_out <= wr_hit_in ? JXL_RESP_OKAY : JXL_RESP_SLVERR;
    end else if (aw_have_q && w_have_q && !w_lane_q) begin
      bvalid_out <= 1'b1;
      bresp_out <= JXL_RESP_OKAY;
    end
  end

  // Read path: address taken, one cycle to look up, data held until rready
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      arready_out <= 1'b0;
      rd_en_out <= 1'b0;
      rd_idx_out <= 12'h000;
      rd_wait_q <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
      rresp_out <= JXL_RESP_OKAY;
    end else begin
      arready_out <= !rd_wait_q && !(arvalid_in && arready_out) && !rvalid_out;
      rd_en_out <= arvalid_in && arready_out;
      if (arvalid_in && arready_out) begin
        rd_idx_out <= araddr_in[13:2];
        rd_wait_q <= 1'b1;
      end
      if (rd_en_out) begin
        rvalid_out <= 1'b1;
        rdata_out <= {24'h000000, rd_data_in};
        rresp_out <= rd_hit_in ? JXL_RESP_OKAY : JXL_RESP_SLVERR;
        rd_wait_q <= 1'b0;
      end else if (rvalid_out && rready_in) begin
        rvalid_out <= 1'b0;
      end
    end
  end
endmodule // jxl_axi_slave

// *** jxl_extra_lane_cfg.sv ***
// Top: link B extra lane and sync header configuration with AXI4-Lite registers
//
// The AXI4-Lite slave port is this design's own decision.
module jxl_extra_lane_cfg (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // AXI4-Lite write
  input wire logic [jxl_pkg::JXL_ADDR_W-1:0] awaddr_in,
  input wire logic awvalid_in,
  output logic awready_out,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] wstrb_in,
  input wire logic wvalid_in,
  output logic wready_out,
  output logic [1:0] bresp_out,
  output logic bvalid_out,
  input wire logic bready_in,
  // AXI4-Lite read
  input wire logic [jxl_pkg::JXL_ADDR_W-1:0] araddr_in,
  input wire logic arvalid_in,
  output logic arready_out,
  output logic [31:0] rdata_out,
  output logic [1:0] rresp_out,
  output logic rvalid_out,
  input wire logic rready_in,
  // Link-level controls from elsewhere in the device
  input wire logic link_global_enable_in,
  input wire logic [7:0] link_mode_lanes_in,
  input wire logic link_mode_is_66b_in,
  input wire logic [3:0] link_test_pattern_select_in,
  input wire logic channel_power_down_in,
  // Lane controls
  output logic [7:0] lane_clk_en_out,
  output logic [7:0] lane_ser_en_out,
  output logic [7:0] lane_ramp_out,
  output logic [3:0] lane_test_pattern_out,
  // Sync header stream controls
  output logic sh_crc12_en_out,
  output logic sh_fec_en_out,
  output logic sh_cmd_en_out,
  output logic [5:0] sh_data_bits_out,
  // Register values for other blocks
  output logic [7:0] downconverter_config_out,
  output logic [7:0] overrange_threshold_zero_out
);
  import jxl_pkg::*;

  logic wr_en, rd_en, wr_hit, rd_hit;
  logic [11:0] wr_idx, rd_idx;
  logic [7:0] wr_data, rd_data;
  logic [7:0] extra_lane_q, sync_mode_q, downconverter_config_q, overrange_threshold_zero_q;
  logic [1:0] sh_sel;
  jxl_sh_t sh_q, sh_d;
  logic sh_valid;

  // Index decode used by both write and read paths
  function automatic logic idx_hit(input logic [11:0] idx);
    idx_hit = (idx == JXL_IDX_EXTRA_LANE) || (idx == JXL_IDX_SYNC_MODE) ||
              (idx == JXL_IDX_DOWNCONVERTER_CONFIG) || (idx == JXL_IDX_OVERRANGE_THRESHOLD_ZERO);
  endfunction

  assign wr_hit = idx_hit(wr_idx);
  assign rd_hit = idx_hit(rd_idx);

  // Bus front end
  jxl_axi_slave u_axi (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in),
    .awready_out(awready_out),
    .wdata_in(wdata_in),
    .wstrb_in(wstrb_in),
    .wvalid_in(wvalid_in),
    .wready_out(wready_out),
    .bresp_out(bresp_out),
    .bvalid_out(bvalid_out),
    .bready_in(bready_in),
    .araddr_in(araddr_in),
    .arvalid_in(arvalid_in),
    .arready_out(arready_out),
    .rdata_out(rdata_out),
    .rresp_out(rresp_out),
    .rvalid_out(rvalid_out),
    .rready_in(rready_in),
    .wr_en_out(wr_en),
    .wr_idx_out(wr_idx),
    .wr_data_out(wr_data),
    .rd_en_out(rd_en),
    .rd_idx_out(rd_idx),
    .rd_data_in(rd_data),
    .wr_hit_in(wr_hit),
    .rd_hit_in(rd_hit)
  );

  // Register storage; all eight bits kept, reserved ones included
  // Writes are not blocked while the link is enabled: software must clear the
  // global enable first, as changing lanes live would glitch the link
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      extra_lane_q <= JXL_RST_EXTRA_LANE;
      sync_mode_q <= JXL_RST_SYNC_MODE;
      downconverter_config_q <= JXL_RST_DOWNCONVERTER_CONFIG;
      overrange_threshold_zero_q <= JXL_RST_OVERRANGE_THRESHOLD_ZERO;
    end else if (wr_en) begin
      case (wr_idx)
        JXL_IDX_EXTRA_LANE: extra_lane_q <= wr_data;
        JXL_IDX_SYNC_MODE: sync_mode_q <= wr_data;
        JXL_IDX_DOWNCONVERTER_CONFIG: downconverter_config_q <= wr_data;
        JXL_IDX_OVERRANGE_THRESHOLD_ZERO: overrange_threshold_zero_q <= wr_data;
        default: ;
      endcase
    end
  end

  // Read mux, sampled by the bus front end one cycle after the address
  always_comb begin
    case (rd_idx)
      JXL_IDX_EXTRA_LANE: rd_data = extra_lane_q;
      JXL_IDX_SYNC_MODE: rd_data = sync_mode_q;
      JXL_IDX_DOWNCONVERTER_CONFIG: rd_data = downconverter_config_q;
      JXL_IDX_OVERRANGE_THRESHOLD_ZERO: rd_data = overrange_threshold_zero_q;
      default: rd_data = 8'h00;
    endcase
  end

  // Lane enables; gated by the global enable so changes land only when enabled
  jxl_lane_decode u_lanes (
    .clock_in(clock_in),
    .nrst_in(nrst_in),
    .mode_lanes_in(link_global_enable_in ? link_mode_lanes_in : 8'h00),
    .extra_lane_in(link_global_enable_in ? extra_lane_q[JXL_LANE_MSB:JXL_LANE_LSB] : 7'h00),
    .extra_ser_in(extra_lane_q[JXL_SER_BIT]),
    .powered_in(!channel_power_down_in),
    .test_sel_in(link_test_pattern_select_in),
    .lane_clk_en_out(lane_clk_en_out),
    .lane_ser_en_out(lane_ser_en_out),
    .lane_ramp_out(lane_ramp_out)
  );

  // Test pattern per link follows the selection; the ramp override is per lane
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      lane_test_pattern_out <= JXL_TEST_OFF;
    end else begin
      lane_test_pattern_out <= link_test_pattern_select_in;
    end
  end

  // Sync header content select; reserved codes fall back to CRC-12
  assign sh_sel = sync_mode_q[1:0];
  assign sh_valid = link_global_enable_in && link_mode_is_66b_in;
  always_comb begin
    case (sh_sel)
      JXL_SH_FEC: sh_d = JXL_SH_OUT_FEC;
      default: sh_d = JXL_SH_OUT_CRC;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sh_q <= JXL_SH_OUT_CRC;
      sh_crc12_en_out <= 1'b0;
      sh_fec_en_out <= 1'b0;
    end else begin
      sh_q <= sh_d;
      case (sh_d)
        JXL_SH_OUT_FEC: begin
          sh_crc12_en_out <= 1'b0;
          sh_fec_en_out <= sh_valid;
        end
        JXL_SH_OUT_CRC: begin
          sh_crc12_en_out <= sh_valid;
          sh_fec_en_out <= 1'b0;
        end
        default: begin
          sh_crc12_en_out <= 1'b0;
          sh_fec_en_out <= 1'b0;
        end
      endcase
    end
  end

  // Command channel never used, sync word width fixed
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      sh_cmd_en_out <= 1'b0;
      sh_data_bits_out <= 6'h00;
    end else begin
      sh_cmd_en_out <= 1'b0;
      sh_data_bits_out <= 6'(JXL_SYNC_BITS);
    end
  end

  // Plain register values for the downconverter and over-range logic
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      downconverter_config_out <= JXL_RST_DOWNCONVERTER_CONFIG;
      overrange_threshold_zero_out <= JXL_RST_OVERRANGE_THRESHOLD_ZERO;
    end else begin
      downconverter_config_out <= downconverter_config_q;
      overrange_threshold_zero_out <= overrange_threshold_zero_q;
    end
  end

  // Assertions
  a_lane_clk_extra: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(link_global_enable_in && !channel_power_down_in && extra_lane_q[1]
      && link_mode_lanes_in[0]) |-> lane_clk_en_out[1])
    else $error("extra lane 1 clock not enabled");
  a_lane_unused_ok: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(link_global_enable_in && !channel_power_down_in && extra_lane_q[3]
      && !link_mode_lanes_in[3]) |-> lane_clk_en_out[3])
    else $error("extra lane ignored when mode leaves it unused");
  a_ser_off_only: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(!extra_lane_q[0] && !link_mode_lanes_in[2]) |-> !lane_ser_en_out[2])
    else $error("serializer on with serializer bit clear");
  a_ser_on_extra: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(link_global_enable_in && !channel_power_down_in && extra_lane_q[0]
      && extra_lane_q[1] && link_mode_lanes_in[0]) |-> lane_ser_en_out[1])
    else $error("serializer of extra lane not enabled");
  a_ramp_extra: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(link_global_enable_in && extra_lane_q[5] && !link_mode_lanes_in[5]
      && link_test_pattern_select_in == JXL_TEST_FIVE) |-> lane_ramp_out[5])
    else $error("ramp missing on extra lane");
  a_pd_wins: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(channel_power_down_in) |-> lane_clk_en_out == 8'h00 && lane_ser_en_out == 8'h00)
    else $error("lanes on while powered down");
  a_ser_contig: assert property (@(posedge clock_in) disable iff (!nrst_in)
    lane_ser_en_out[4] |-> &lane_clk_en_out[4:0])
    else $error("serializer clocked without lower lanes");
  a_sh_gate: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(!link_mode_is_66b_in) |-> !sh_crc12_en_out && !sh_fec_en_out)
    else $error("sync header active outside 64b66b");
  a_sh_fec: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(sync_mode_q[1:0] == JXL_SH_FEC && sh_valid) |-> sh_fec_en_out && !sh_crc12_en_out)
    else $error("FEC not selected");
  a_cmd_idle: assert property (@(posedge clock_in) disable iff (!nrst_in)
    $past(nrst_in) |-> !sh_cmd_en_out && sh_data_bits_out == 6'h20)
    else $error("command channel or sync width wrong");
  c_extra_ser: cover property (@(posedge clock_in) lane_ser_en_out[7]);
  c_ramp: cover property (@(posedge clock_in) |lane_ramp_out);
  c_fec: cover property (@(posedge clock_in) sh_fec_en_out);
endmodule // jxl_extra_lane_cfg

// *** jxl_extra_lane_cfg_tb.sv ***
// Self-checking bench for the link B extra lane configuration block
module jxl_extra_lane_cfg_tb;
  import jxl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [13:0] awaddr = 14'h0;
  logic [13:0] araddr = 14'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, crc, fec, cmd;
  logic [1:0] bresp, rresp, hdr_kind;
  logic [31:0] rdata;
  logic en = 1'b0, is66 = 1'b0, pd = 1'b0;
  logic [7:0] mode = 8'h00;
  logic [3:0] pat = 4'h0;
  logic [7:0] clk_en, ser_en, ramp, ddc, ovr;
  logic [3:0] tp_out, lanes_rx;
  logic [5:0] dbits;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [11:0] idxs [4] = '{JXL_IDX_EXTRA_LANE, JXL_IDX_SYNC_MODE, JXL_IDX_DOWNCONVERTER_CONFIG, JXL_IDX_OVERRANGE_THRESHOLD_ZERO};
  logic [7:0] rsts [4] = '{JXL_RST_EXTRA_LANE, JXL_RST_SYNC_MODE, JXL_RST_DOWNCONVERTER_CONFIG, JXL_RST_OVERRANGE_THRESHOLD_ZERO};
  logic [7:0] vals [4];
  logic [7:0] cx [4] = '{8'hFF, 8'hFE, 8'hFF, 8'h03};
  logic [7:0] cm [4] = '{8'h01, 8'h00, 8'h01, 8'h01};
  logic [3:0] pats [4] = '{JXL_TEST_OFF, JXL_TEST_RAMP, JXL_TEST_FIVE, 4'h3};

  jxl_extra_lane_cfg i_jxl_extra_lane_cfg (
    .clock_in(clock_in), .nrst_in(nrst_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(wstrb), .wvalid_in(wvalid), .wready_out(wready),
    .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready),
    .rdata_out(rdata), .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready),
    .link_global_enable_in(en), .link_mode_lanes_in(mode), .link_mode_is_66b_in(is66),
    .link_test_pattern_select_in(pat), .channel_power_down_in(pd),
    .lane_clk_en_out(clk_en), .lane_ser_en_out(ser_en), .lane_ramp_out(ramp),
    .lane_test_pattern_out(tp_out), .sh_crc12_en_out(crc), .sh_fec_en_out(fec),
    .sh_cmd_en_out(cmd), .sh_data_bits_out(dbits),
    .downconverter_config_out(ddc), .overrange_threshold_zero_out(ovr)
  );

  jxl_rx_model i_jxl_rx_model (
    .clock_in(clock_in), .nrst_in(nrst_in), .lane_ser_en_in(ser_en),
    .sh_crc12_en_in(crc), .sh_fec_en_in(fec), .sh_cmd_en_in(cmd),
    .lanes_rx_out(lanes_rx), .hdr_kind_out(hdr_kind)
  );

  // 100 ns clock
  initial begin
    forever #50 clock_in = ~clock_in;
  end

  // Verdict in one place, for the normal end and for a hang
  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs well under 3000 cycles
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: response got %h exp %h", $time, got, exp);
    end
  endtask

  // Write: both halves offered together, each released when taken
  task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clock_in);
    awaddr <= {idx, 2'h0};
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock_in);
      if (awvalid && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    while (bvalid !== 1'b1) @(posedge clock_in);
    chk_resp(bresp, JXL_RESP_OKAY);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clock_in);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clock_in);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // Expected {clock enables, serializer enables, ramp flags}
  function automatic logic [23:0] exp_lanes(input logic [7:0] m, input logic [7:0] x,
      input logic e, input logic p, input logic [3:0] t);
    logic [7:0] c;
    logic [7:0] s;
    logic [7:0] r;
    logic all_on;
    all_on = 1'b1;
    for (int n = 0; n < 8; n++) begin
      c[n] = !p && e && (m[n] || (n > 0 && x[n]));
      all_on = all_on && c[n];
      s[n] = !p && (m[n] || (n > 0 && x[n] && x[0])) && all_on;
      r[n] = e && n > 0 && x[n] && !m[n] && (t == 4'h0 || t == 4'h5);
    end
    return {c, s, r};
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    logic [7:0] x;
    logic [7:0] m;
    logic [7:0] v;
    logic [23:0] e;
    void'($urandom(84));
    repeat (6) @(posedge clock_in);
    nrst_in <= 1'b1;
    // Reset values, then an unmapped index
    for (int i = 0; i < 4; i++) begin
      axi_rd(idxs[i], d, rs);
      chk_val(d, {24'h0, rsts[i]}, "reset value");
    end
    axi_rd(12'h20C, d, rs);
    chk_resp(rs, JXL_RESP_SLVERR);
    chk_val(d, 32'h0, "unmapped data");
    // One random value per register stores and reads back, reserved bits too
    for (int i = 0; i < 4; i++) begin
      vals[i] = 8'($urandom);
      axi_wr(idxs[i], vals[i]);
      axi_rd(idxs[i], d, rs);
      chk_resp(rs, JXL_RESP_OKAY);
      chk_val(d, {24'h0, vals[i]}, "read back");
    end
    // Byte lane 0 off: accepted with OKAY, nothing stored, bus still free after
    wstrb <= 4'hE;
    axi_wr(JXL_IDX_OVERRANGE_THRESHOLD_ZERO, ~vals[3]);
    wstrb <= 4'hF;
    axi_rd(JXL_IDX_OVERRANGE_THRESHOLD_ZERO, d, rs);
    chk_val(d, {24'h0, vals[3]}, "masked write");
    chk_val({24'h0, ddc}, {24'h0, vals[2]}, "downconverter copy");
    chk_val({24'h0, ovr}, {24'h0, vals[3]}, "threshold copy");
    // Lane decode: corner cases first, then random settings
    for (int k = 0; k < 48; k++) begin
      x = (k < 4) ? cx[k] : 8'($urandom);
      m = (k < 4) ? cm[k] : 8'($urandom);
      @(posedge clock_in);
      en <= 1'b0;
      axi_wr(JXL_IDX_EXTRA_LANE, x);
      @(posedge clock_in);
      mode <= m;
      pd <= (k == 2) || (k > 3 && $urandom % 4 == 0);
      pat <= pats[$urandom % 4];
      en <= (k < 4) || ($urandom % 6 != 0);
      repeat (3) @(posedge clock_in);
      e = exp_lanes(mode, x, en, pd, pat);
      chk_val({24'h0, clk_en}, {24'h0, e[23:16]}, "clock enables");
      chk_val({24'h0, ser_en}, {24'h0, e[15:8]}, "serializers");
      chk_val({24'h0, ramp}, {24'h0, e[7:0]}, "ramp lanes");
      chk_val({28'h0, tp_out}, {28'h0, pat}, "test pattern");
      chk_val({28'h0, lanes_rx}, 32'($countones(e[15:8])), "lanes received");
    end
    // Sync header content over all codes, with and without 64b/66b
    for (int f = 0; f < 8; f++) begin
      @(posedge clock_in);
      en <= 1'b0;
      v = {6'($urandom), 2'(f)};
      axi_wr(JXL_IDX_SYNC_MODE, v);
      @(posedge clock_in);
      en <= 1'b1;
      is66 <= f[2];
      repeat (3) @(posedge clock_in);
      chk_val({29'h0, cmd, crc, fec}, {29'h0, 1'b0, f[2] && v[1:0] != 2'h2,
        f[2] && v[1:0] == 2'h2}, "header select");
      chk_val({26'h0, dbits}, JXL_SYNC_BITS, "sync word bits");
      chk_val({30'h0, hdr_kind}, {30'h0, f[2] && v[1:0] == 2'h2,
        f[2] && v[1:0] != 2'h2}, "header at far end");
    end
    conclude();
  end
endmodule // jxl_extra_lane_cfg_tb

// *** jxl_lane_decode.sv ***
// Lane decode: per-lane clock, serializer and ramp enables from configuration
module jxl_lane_decode (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // Configuration
  input wire logic [7:0] mode_lanes_in,
  input wire logic [7:1] extra_lane_in,
  input wire logic extra_ser_in,
  input wire logic powered_in,
  input wire logic [3:0] test_sel_in,
  // Lane controls
  output logic [7:0] lane_clk_en_out,
  output logic [7:0] lane_ser_en_out,
  output logic [7:0] lane_ramp_out
);
  import jxl_pkg::*;
  logic [7:0] clk_d, ser_d, ramp_d;
  logic [7:0] want_ser;
  logic test_ramp;

  assign test_ramp = (test_sel_in == JXL_TEST_OFF) || (test_sel_in == JXL_TEST_FIVE);

  // Per-lane enables; power-down forces clock and serializer off, ramp flags ignore it
  generate
    for (genvar n = 0; n < JXL_LANES; n++) begin : g_lane
      logic extra;
      if (n == 0) begin : g_zero
        assign extra = 1'b0;
      end else begin : g_more
        assign extra = extra_lane_in[n];
      end
      assign clk_d[n] = powered_in && (mode_lanes_in[n] || extra);
      assign want_ser[n] = mode_lanes_in[n] || (extra && extra_ser_in);
      // Serializer clock only reaches lane n if every lower lane is enabled
      assign ser_d[n] = powered_in && want_ser[n] && (&clk_d[n:0]);
      assign ramp_d[n] = extra && !mode_lanes_in[n] && test_ramp;
    end
  endgenerate

  // Registered so every top output comes from a flip-flop
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      lane_clk_en_out <= 8'h00;
      lane_ser_en_out <= 8'h00;
      lane_ramp_out <= 8'h00;
    end else begin
      lane_clk_en_out <= clk_d;
      lane_ser_en_out <= ser_d;
      lane_ramp_out <= ramp_d;
    end
  end
endmodule // jxl_lane_decode

// *** jxl_pkg.sv ***
// Package: register map, field layout and decode constants for the link B lane block
package jxl_pkg;
  // Register indices as printed (not all multiples of four, byte address = 4 * index)
  localparam logic [11:0] JXL_IDX_EXTRA_LANE = 12'h20B;
  localparam logic [11:0] JXL_IDX_SYNC_MODE = 12'h20F;
  localparam logic [11:0] JXL_IDX_DOWNCONVERTER_CONFIG = 12'h210;
  localparam logic [11:0] JXL_IDX_OVERRANGE_THRESHOLD_ZERO = 12'h211;
  localparam int JXL_ADDR_W = 14;
  // Reset values
  localparam logic [7:0] JXL_RST_EXTRA_LANE = 8'h00;
  localparam logic [7:0] JXL_RST_SYNC_MODE = 8'h00;
  localparam logic [7:0] JXL_RST_DOWNCONVERTER_CONFIG = 8'h00;
  localparam logic [7:0] JXL_RST_OVERRANGE_THRESHOLD_ZERO = 8'hF2;
  // Field positions
  localparam int JXL_SER_BIT = 0;
  localparam int JXL_LANE_LSB = 1;
  localparam int JXL_LANE_MSB = 7;
  localparam int JXL_LANES = 8;
  // Sync header content encodings
  localparam logic [1:0] JXL_SH_CRC12 = 2'h0;
  localparam logic [1:0] JXL_SH_FEC = 2'h2;
  // Test pattern codes
  localparam logic [3:0] JXL_TEST_OFF = 4'h0;
  localparam logic [3:0] JXL_TEST_RAMP = 4'h4;
  localparam logic [3:0] JXL_TEST_FIVE = 4'h5;
  // Sync word bits per multiblock
  localparam int JXL_SYNC_BITS = 32;
  // AXI responses
  localparam logic [1:0] JXL_RESP_OKAY = 2'h0;
  localparam logic [1:0] JXL_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    JXL_SH_OUT_CRC = 2'h1,
    JXL_SH_OUT_FEC = 2'h2
  } jxl_sh_t;
endpackage

// *** jxl_rx_model.sv ***
// Receiver model: counts serialized lanes and classifies the sync header stream
module jxl_rx_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic nrst_in,
  // From the transmitting device
  input wire logic [7:0] lane_ser_en_in,
  input wire logic sh_crc12_en_in,
  input wire logic sh_fec_en_in,
  input wire logic sh_cmd_en_in,
  // What the far end sees
  output logic [3:0] lanes_rx_out,
  output logic [1:0] hdr_kind_out
);
  // A command word cannot be decoded here, so it reads as kind 3
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      lanes_rx_out <= 4'h0;
      hdr_kind_out <= 2'h0;
    end else begin
      lanes_rx_out <= 4'($countones(lane_ser_en_in));
      hdr_kind_out <= sh_cmd_en_in ? 2'h3 : {sh_fec_en_in, sh_crc12_en_in};
    end
  end
endmodule // jxl_rx_model
